// file: common/mdo_defs.vh
// constants for the data-operation execution block
`ifndef MDO_DEFS_VH
`define MDO_DEFS_VH

// operation select codes
`define MDO_OP_SWAP_MEM    5'h00
`define MDO_OP_SWAP_ACC    5'h01
`define MDO_OP_SKZ         5'h02
`define MDO_OP_SKZ_MOV     5'h03
`define MDO_OP_SKZ_BIT     5'h04
`define MDO_OP_TBL_PAGE    5'h05
`define MDO_OP_TBL_LAST    5'h06
`define MDO_OP_ITBL_PAGE   5'h07
`define MDO_OP_ITBL_LAST   5'h08
`define MDO_OP_XOR_ACC     5'h09
`define MDO_OP_XOR_MEM     5'h0a
`define MDO_OP_XOR_IMM     5'h0b
`define MDO_OP_ADC_ACC     5'h0c
`define MDO_OP_ADC_MEM     5'h0d
`define MDO_OP_ADD_ACC     5'h0e
`define MDO_OP_ADD_MEM     5'h0f
`define MDO_OP_AND_ACC     5'h10
`define MDO_OP_AND_MEM     5'h11
`define MDO_OP_CLR         5'h12
`define MDO_OP_CLR_BIT     5'h13
`define MDO_OP_CPL         5'h14
`define MDO_OP_CPL_ACC     5'h15
`define MDO_OP_DAA         5'h16
`define MDO_OP_DEC         5'h17
`define MDO_OP_DEC_ACC     5'h18
`define MDO_OP_INC         5'h19
`define MDO_OP_INC_ACC     5'h1a
`define MDO_OP_MOV_TO_ACC  5'h1b
`define MDO_OP_MOV_TO_MEM  5'h1c

// flag vector bit positions
`define MDO_FLAG_C         0
`define MDO_FLAG_HC        1
`define MDO_FLAG_Z         2
`define MDO_FLAG_SRNG      3
`define MDO_FLAG_SRES      4

// reset values
`define MDO_ACC_RST        8'h00
`define MDO_FLAGS_RST      5'h00
`define MDO_TBL_RST        8'h00

// decimal adjust figures
`define MDO_BCD_MAX        4'h9
`define MDO_BCD_FIX        4'h6

// cycles a taken skip costs beyond the normal finish
`define MDO_SKIP_DUMMY     1

`endif

// file: verilog/mdo_alu.v
// combinational result and flag logic for one data operation
`include "mdo_defs.vh"
`default_nettype none
module mdo_alu (
  input  wire [4:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] mem,
  input  wire [7:0] imm,
  input  wire [2:0] bit_sel,
  input  wire [4:0] flags_in,
  output reg  [7:0] res,
  output reg        to_acc,
  output reg        to_mem,
  output reg        skip,
  output reg  [4:0] flags_out
);
  wire       c_in  = flags_in[`MDO_FLAG_C];
  wire       hc_in = flags_in[`MDO_FLAG_HC];
  wire       use_c = (op == `MDO_OP_ADC_ACC) || (op == `MDO_OP_ADC_MEM);
  wire [8:0] sum9  = {1'b0, acc} + {1'b0, mem} + {8'h00, use_c & c_in};
  wire [4:0] low5  = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} +
                     {4'h0, use_c & c_in};
  wire       srng  = (acc[7] == mem[7]) && (sum9[7] != acc[7]);
  // decimal adjust works on the accumulator and the carry pair
  wire       lo_fix = (acc[3:0] > `MDO_BCD_MAX) || hc_in;
  wire       hi_fix = (acc[7:4] > `MDO_BCD_MAX) || c_in;
  wire [8:0] daa9  = {1'b0, acc} +
                     {1'b0, (hi_fix ? `MDO_BCD_FIX : 4'h0),
                            (lo_fix ? `MDO_BCD_FIX : 4'h0)};
  wire [7:0] bmask = 8'h01 << bit_sel;

  // one case picks result, destination, skip and flag update
  always @* begin
    res       = mem;
    to_acc    = 1'b0;
    to_mem    = 1'b0;
    skip      = 1'b0;
    flags_out = flags_in;
    case (op)
      `MDO_OP_SWAP_MEM: begin
        res    = {mem[3:0], mem[7:4]};
        to_mem = 1'b1;
      end
      `MDO_OP_SWAP_ACC: begin
        res    = {mem[3:0], mem[7:4]};
        to_acc = 1'b1;
      end
      `MDO_OP_SKZ:     skip = (mem == 8'h00);
      `MDO_OP_SKZ_MOV: begin
        to_acc = 1'b1;
        skip   = (mem == 8'h00);
      end
      `MDO_OP_SKZ_BIT: skip = ~mem[bit_sel];
      `MDO_OP_XOR_ACC, `MDO_OP_XOR_MEM, `MDO_OP_XOR_IMM: begin
        res    = acc ^ ((op == `MDO_OP_XOR_IMM) ? imm : mem);
        to_acc = (op != `MDO_OP_XOR_MEM);
        to_mem = (op == `MDO_OP_XOR_MEM);
        flags_out[`MDO_FLAG_Z] = (res == 8'h00);
      end
      `MDO_OP_ADC_ACC, `MDO_OP_ADC_MEM,
      `MDO_OP_ADD_ACC, `MDO_OP_ADD_MEM: begin
        res    = sum9[7:0];
        to_acc = (op == `MDO_OP_ADC_ACC) || (op == `MDO_OP_ADD_ACC);
        to_mem = (op == `MDO_OP_ADC_MEM) || (op == `MDO_OP_ADD_MEM);
        flags_out[`MDO_FLAG_C]  = sum9[8];
        flags_out[`MDO_FLAG_HC]   = low5[4];
        flags_out[`MDO_FLAG_SRNG] = srng;
        flags_out[`MDO_FLAG_SRES] = srng ^ sum9[7];
        flags_out[`MDO_FLAG_Z]  = (sum9[7:0] == 8'h00);
      end
      `MDO_OP_AND_ACC, `MDO_OP_AND_MEM: begin
        res    = acc & mem;
        to_acc = (op == `MDO_OP_AND_ACC);
        to_mem = (op == `MDO_OP_AND_MEM);
        flags_out[`MDO_FLAG_Z] = (res == 8'h00);
      end
      `MDO_OP_CLR: begin
        res    = 8'h00;
        to_mem = 1'b1;
      end
      `MDO_OP_CLR_BIT: begin
        res    = mem & ~bmask;
        to_mem = 1'b1;
      end
      `MDO_OP_CPL, `MDO_OP_CPL_ACC: begin
        res    = ~mem;
        to_acc = (op == `MDO_OP_CPL_ACC);
        to_mem = (op == `MDO_OP_CPL);
        flags_out[`MDO_FLAG_Z] = (res == 8'h00);
      end
      `MDO_OP_DAA: begin
        res    = daa9[7:0];
        to_mem = 1'b1;
        // carry only ever sets here so a chained decimal add survives
        flags_out[`MDO_FLAG_C] = c_in | daa9[8];
      end
      `MDO_OP_DEC, `MDO_OP_DEC_ACC: begin
        res    = mem - 8'h01;
        to_acc = (op == `MDO_OP_DEC_ACC);
        to_mem = (op == `MDO_OP_DEC);
        flags_out[`MDO_FLAG_Z] = (res == 8'h00);
      end
      `MDO_OP_INC, `MDO_OP_INC_ACC: begin
        res    = mem + 8'h01;
        to_acc = (op == `MDO_OP_INC_ACC);
        to_mem = (op == `MDO_OP_INC);
        flags_out[`MDO_FLAG_Z] = (res == 8'h00);
      end
      `MDO_OP_MOV_TO_ACC: to_acc = 1'b1;
      `MDO_OP_MOV_TO_MEM: begin
        res    = acc;
        to_mem = 1'b1;
      end
      default: res = mem;
    endcase
  end
endmodule // mdo_alu
`default_nettype wire

// file: verilog/mdo_tbl_addr.v
// forms the program-memory address of a table read
`default_nettype none
module mdo_tbl_addr #(
  parameter PROG_AW = 16
) (
  input  wire [7:0]         ptr_lo,
  input  wire [7:0]         ptr_hi,
  input  wire               last_page,
  output wire [PROG_AW-1:0] addr
);
  // the last page has every upper address bit set
  wire [15:0] page_addr = {ptr_hi, ptr_lo};
  wire [15:0] last_addr = {8'hff, ptr_lo};
  wire [15:0] pick      = last_page ? last_addr : page_addr;
  assign addr = pick[PROG_AW-1:0];
endmodule // mdo_tbl_addr
`default_nettype wire

// file: verilog/mdo_exec.v
// executes nibble, skip, table-read, xor and long data operations
// What this block does
// - memory nibble swap writes back, flags kept
// - swap to accumulator, memory and flags kept
// - skip next when addressed byte is zero
// - taken skip adds one dummy cycle
// - copy byte to accumulator, skip if zero
// - skip next when selected bit is zero
// - page read: low to memory, high register
// - last-page read uses low pointer only
// - incrementing reads bump low pointer first
// - xor into accumulator or memory, zero flag
// - long forms reach every data address directly
// - add with carry updates five flags
// - add without carry updates five flags
// - and into accumulator or memory, zero flag
// - clear byte or one bit, no flags
// - invert byte to memory or accumulator
// - decimal adjust adds six to each nibble above nine or with its carry set
// - decimal adjust changes carry flag only
// - decrement to memory or accumulator, zero flag
// - increment to memory or accumulator, zero flag
// - move between byte and accumulator, no flags
`include "mdo_defs.vh"
`default_nettype none
module mdo_exec #(
  parameter DATA_AW = 12,
  parameter PROG_AW = 16
) (
  input  wire               core_clk,
  input  wire               rst,
  // operation request from the core sequencer
  input  wire               op_start,
  input  wire [4:0]         op_sel,
  input  wire [DATA_AW-1:0] op_addr,
  input  wire [2:0]         op_bit,
  input  wire [7:0]         op_imm,
  output wire               op_busy,
  output wire               op_done,
  output wire               op_skip,
  output wire               op_dummy,
  // core-side loads of the architectural registers
  input  wire               acc_load,
  input  wire [7:0]         acc_load_val,
  input  wire               flags_load,
  input  wire [4:0]         flags_load_val,
  input  wire               ptr_lo_load,
  input  wire [7:0]         ptr_lo_load_val,
  input  wire               ptr_hi_load,
  input  wire [7:0]         ptr_hi_load_val,
  // architectural state
  output wire [7:0]         acc,
  output wire [4:0]         status_flags,
  output wire [7:0]         table_pointer_low,
  output wire [7:0]         table_pointer_high,
  output wire [7:0]         table_high_byte,
  // data memory port, read data one cycle after the read strobe
  output wire [DATA_AW-1:0] mem_addr,
  output wire               mem_rd_en,
  input  wire [7:0]         mem_rdata,
  output wire               mem_wr_en,
  output wire [7:0]         mem_wdata,
  // program memory port, read data one cycle after the read strobe
  output wire [PROG_AW-1:0] prog_addr,
  output wire               prog_rd_en,
  input  wire [15:0]        prog_rdata
);
  // sequencer states; data ops use idle, rwait, exec and dummy only
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_RWAIT = 3'h1;
  localparam [2:0] S_EXEC  = 3'h2;
  localparam [2:0] S_DUMMY = 3'h3;
  localparam [2:0] S_TINC  = 3'h4;
  localparam [2:0] S_TRD   = 3'h5;
  localparam [2:0] S_TWAIT = 3'h6;
  localparam [2:0] S_TWR   = 3'h7;

  // request capture, architectural state and port registers
  reg [2:0]         state_ff;
  reg [2:0]         nxt_state;
  reg [4:0]         op_ff;
  reg [2:0]         bit_ff;
  reg [7:0]         imm_ff;
  reg [DATA_AW-1:0] addr_ff;
  reg [7:0]         acc_ff;
  reg [4:0]         flags_ff;
  reg [7:0]         ptr_lo_ff;
  reg [7:0]         ptr_hi_ff;
  reg [7:0]         tbl_hi_ff;
  reg               mem_rd_ff;
  reg               mem_wr_ff;
  reg [7:0]         mem_wdata_ff;
  reg               prog_rd_ff;
  reg [PROG_AW-1:0] prog_addr_ff;
  reg               done_ff;
  reg               skip_ff;

  // results of the two helper modules
  wire [7:0]         alu_res;
  wire               alu_to_acc;
  wire               alu_to_mem;
  wire               alu_skip;
  wire [4:0]         alu_flags;
  wire [PROG_AW-1:0] tbl_addr;

  // table operations go through the program-memory path
  wire start_tbl = (op_sel == `MDO_OP_TBL_PAGE) ||
                   (op_sel == `MDO_OP_TBL_LAST) ||
                   (op_sel == `MDO_OP_ITBL_PAGE) ||
                   (op_sel == `MDO_OP_ITBL_LAST);
  // decoded from the captured code, op_sel may move on once taken
  wire is_inc    = (op_ff == `MDO_OP_ITBL_PAGE) ||
                   (op_ff == `MDO_OP_ITBL_LAST);
  wire is_last   = (op_ff == `MDO_OP_TBL_LAST) ||
                   (op_ff == `MDO_OP_ITBL_LAST);
  // limitation: a request while busy is dropped with no sign, so the
  // core sequencer must wait for op_done before the next one
  wire take      = op_start && (state_ff == S_IDLE);

  // the operand is used straight off the memory port in the exec cycle
  mdo_alu u_alu (
    .op        (op_ff),
    .acc       (acc_ff),
    .mem       (mem_rdata),
    .imm       (imm_ff),
    .bit_sel   (bit_ff),
    .flags_in  (flags_ff),
    .res       (alu_res),
    .to_acc    (alu_to_acc),
    .to_mem    (alu_to_mem),
    .skip      (alu_skip),
    .flags_out (alu_flags)
  );

  // program address of a table read, formed from the pointer pair
  mdo_tbl_addr #(
    .PROG_AW (PROG_AW)
  ) u_tbl_addr (
    .ptr_lo    (ptr_lo_ff),
    .ptr_hi    (ptr_hi_ff),
    .last_page (is_last),
    .addr      (tbl_addr)
  );

  // sequencing of one operation
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      // table codes go straight to the pointer slot, no operand read
      S_IDLE: begin
        if (op_start) begin
          nxt_state = start_tbl ? S_TINC : S_RWAIT;
        end
      end
      // operand read in flight, data stands in the next cycle
      S_RWAIT: nxt_state = S_EXEC;
      // a taken skip burns one dummy cycle while the next op fetches
      S_EXEC:  nxt_state = alu_skip ? S_DUMMY : S_IDLE;
      S_DUMMY: nxt_state = S_IDLE;
      // the bump slot is spent by plain reads too, so all four match
      S_TINC:  nxt_state = S_TRD;
      // program read goes out with the settled pointer
      S_TRD:   nxt_state = S_TWAIT;
      // program read strobe on the port, word arrives in the next cycle
      S_TWAIT: nxt_state = S_TWR;
      // low byte to memory, high byte to its register
      S_TWR:   nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // state register and request capture
  always @(posedge core_clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff    <= 5'h00;
      bit_ff   <= 3'h0;
      imm_ff   <= 8'h00;
      addr_ff  <= {DATA_AW{1'b0}};
    end else begin
      state_ff <= nxt_state;
      if (take) begin
        op_ff   <= op_sel;
        bit_ff  <= op_bit;
        imm_ff  <= op_imm;
        // full-width address: no bank limit on the long forms
        addr_ff <= op_addr;
      end
    end
  end

  // data memory strobes; the read is issued even for clear and move
  // so every data operation without a taken skip has the same length
  always @(posedge core_clk) begin
    if (rst) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end else begin
      mem_rd_ff <= take && !start_tbl;
      mem_wr_ff <= 1'b0;
      if (state_ff == S_EXEC && alu_to_mem) begin
        mem_wr_ff    <= 1'b1;
        mem_wdata_ff <= alu_res;
      end else if (state_ff == S_TWR) begin
        mem_wr_ff    <= 1'b1;
        mem_wdata_ff <= prog_rdata[7:0];
      end
    end
  end

  // accumulator and flags: core loads only while idle
  always @(posedge core_clk) begin
    if (rst) begin
      acc_ff   <= `MDO_ACC_RST;
      flags_ff <= `MDO_FLAGS_RST;
    end else if (state_ff == S_EXEC) begin
      if (alu_to_acc) begin
        acc_ff <= alu_res;
      end
      // the alu vector is taken whole; flagless ops pass it through
      flags_ff <= alu_flags;
    end else if (state_ff == S_IDLE && !op_start) begin
      // a load that meets op_start is dropped: the operation wins
      if (acc_load) begin
        acc_ff <= acc_load_val;
      end
      if (flags_load) begin
        flags_ff <= flags_load_val;
      end
    end
  end

  // table pointer pair and table high-byte register
  always @(posedge core_clk) begin
    if (rst) begin
      ptr_lo_ff <= `MDO_TBL_RST;
      ptr_hi_ff <= `MDO_TBL_RST;
      tbl_hi_ff <= `MDO_TBL_RST;
    end else if (state_ff == S_TINC) begin
      if (is_inc) begin
        ptr_lo_ff <= ptr_lo_ff + 8'h01;
      end
    end else if (state_ff == S_TWR) begin
      tbl_hi_ff <= prog_rdata[15:8];
    end else if (state_ff == S_IDLE && !op_start) begin
      if (ptr_lo_load) begin
        ptr_lo_ff <= ptr_lo_load_val;
      end
      if (ptr_hi_load) begin
        ptr_hi_ff <= ptr_hi_load_val;
      end
    end
  end

  // program read issued after the pointer has settled
  always @(posedge core_clk) begin
    if (rst) begin
      prog_rd_ff   <= 1'b0;
      prog_addr_ff <= {PROG_AW{1'b0}};
    end else begin
      // registered address keeps the program port free of decode glitches
      prog_rd_ff <= (state_ff == S_TRD);
      if (state_ff == S_TRD) begin
        prog_addr_ff <= tbl_addr;
      end
    end
  end

  // completion and skip reporting
  always @(posedge core_clk) begin
    if (rst) begin
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      // done marks the first idle cycle, a new request may meet it
      done_ff <= (state_ff != S_IDLE) && (nxt_state == S_IDLE);
      skip_ff <= (state_ff == S_EXEC) && alu_skip;
    end
  end

  // handshake outputs: busy and dummy from the state register, done and skip from their own flops
  assign op_busy            = (state_ff != S_IDLE);
  assign op_done            = done_ff;
  assign op_skip            = skip_ff;
  assign op_dummy           = (state_ff == S_DUMMY);

  // architectural state
  assign acc                = acc_ff;
  assign status_flags       = flags_ff;
  assign table_pointer_low  = ptr_lo_ff;
  assign table_pointer_high = ptr_hi_ff;
  assign table_high_byte    = tbl_hi_ff;

  // memory ports, every one from a flip-flop
  assign mem_addr           = addr_ff;
  assign mem_rd_en          = mem_rd_ff;
  assign mem_wr_en          = mem_wr_ff;
  assign mem_wdata          = mem_wdata_ff;
  assign prog_addr          = prog_addr_ff;
  assign prog_rd_en         = prog_rd_ff;
endmodule // mdo_exec
`default_nettype wire

// file: verilog/mdo_pad_unused.v
// spare design source: holds no module and no logic
`default_nettype none
`default_nettype wire

// file: bench/mdo_exec_monitor.sv
// concurrent port checks for the data-operation execution block
`include "mdo_defs.vh"
`default_nettype none
module mdo_exec_monitor #(
  parameter DATA_AW = 12,
  parameter PROG_AW = 16
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               op_start,
  input wire logic [4:0]         op_sel,
  input wire logic [DATA_AW-1:0] op_addr,
  input wire logic               op_busy,
  input wire logic               op_done,
  input wire logic               op_skip,
  input wire logic               op_dummy,
  input wire logic [4:0]         status_flags,
  input wire logic [7:0]         table_pointer_low,
  input wire logic [7:0]         table_pointer_high,
  input wire logic [DATA_AW-1:0] mem_addr,
  input wire logic               mem_rd_en,
  input wire logic               mem_wr_en,
  input wire logic [PROG_AW-1:0] prog_addr,
  input wire logic               prog_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] sel_ff;
  logic       tbl_sel;
  logic       last_sel;
  logic       quiet_sel;

  // keep the accepted code, the request port may move on once taken
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_ff <= 5'h00;
    end else if (op_start && !op_busy) begin
      sel_ff <= op_sel;
    end
  end

  // codes 0..8 and clear/move never touch the flags
  assign tbl_sel = (op_sel >= `MDO_OP_TBL_PAGE) && (op_sel <= 5'h08);
  assign last_sel = (sel_ff == `MDO_OP_TBL_LAST) ||
                    (sel_ff == `MDO_OP_ITBL_LAST);
  assign quiet_sel = (sel_ff <= 5'h08) || (sel_ff == `MDO_OP_CLR) ||
                     (sel_ff == `MDO_OP_CLR_BIT) || (sel_ff >= 5'h1b);

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_done_after_busy: assert property (
    $fell(op_busy) && !$past(rst) |-> op_done)
    else $error("done pulse missing after busy");
  chk_skip_dummy: assert property (
    op_skip |-> op_dummy && op_busy)
    else $error("skip pulse without dummy cycle");
  chk_dummy_single: assert property (
    op_dummy |=> !op_dummy && op_done && !op_busy)
    else $error("dummy cycle not single or not last");
  chk_read_addr: assert property (
    op_start && !op_busy && !tbl_sel |=>
      mem_rd_en && op_busy && mem_addr == $past(op_addr))
    else $error("operand read missing or misaddressed");
  chk_write_done: assert property (
    mem_wr_en |-> op_done)
    else $error("memory write outside finishing cycle");
  chk_prog_done: assert property (
    prog_rd_en |-> ##2 op_done)
    else $error("table read did not finish in two cycles");
  chk_last_page: assert property (
    prog_rd_en && last_sel |->
      prog_addr == {{(PROG_AW-8){1'b1}}, table_pointer_low})
    else $error("last page address wrong");
  chk_page_addr: assert property (
    prog_rd_en && !last_sel |->
      prog_addr == PROG_AW'({table_pointer_high, table_pointer_low}))
    else $error("page address wrong");
  chk_ptr_lo_bump: assert property (
    op_start && !op_busy && (op_sel == `MDO_OP_ITBL_PAGE ||
      op_sel == `MDO_OP_ITBL_LAST) |=> ##1
      table_pointer_low == $past(table_pointer_low, 2) + 8'h01)
    else $error("low pointer not bumped before read");
  chk_flags_quiet: assert property (
    op_busy && quiet_sel |=> $stable(status_flags))
    else $error("flags changed by flagless operation");
  chk_daa_carry: assert property (
    op_busy && sel_ff == `MDO_OP_DAA |=>
      status_flags[4:1] == $past(status_flags[4:1]) &&
      (status_flags[0] || !$past(status_flags[0])))
    else $error("decimal adjust touched flags beyond carry");
endmodule // mdo_exec_monitor
`default_nettype wire

// file: bench/tb_mdo_exec.sv
// self-checking bench for the data-operation execution block
`include "mdo_defs.vh"
`default_nettype none
module tb_mdo_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, op_start, acc_load, flags_load;
  logic        ptr_lo_load, ptr_hi_load;
  logic [4:0]  op_sel, flags_load_val, ef;
  logic [11:0] op_addr;
  logic [2:0]  op_bit;
  logic [7:0]  op_imm, acc_load_val, ptr_lo_load_val, ptr_hi_load_val;
  logic [7:0]  mem_rdata, ea, em, et, ep;
  logic [15:0] prog_rdata;
  logic        es;
  wire         op_busy, op_done, op_skip, op_dummy, mem_rd_en;
  wire         mem_wr_en, prog_rd_en;
  wire  [7:0]  acc, table_pointer_low, table_pointer_high;
  wire  [7:0]  table_high_byte, mem_wdata;
  wire  [4:0]  status_flags;
  wire  [11:0] mem_addr;
  wire  [15:0] prog_addr;
  logic [7:0]  dmem [0:4095];
  int          n_mismatch, total_checks;
  // three operand sets: sign overflow, zero operand, all-ones operand
  logic [7:0]  va [3] = '{8'h80, 8'h3c, 8'h7f};
  logic [7:0]  vm [3] = '{8'h80, 8'h00, 8'hff};
  logic [4:0]  vf [3] = '{5'h01, 5'h02, 5'h1c};
  logic [2:0]  vb [3] = '{3'h3, 3'h7, 3'h0};
  logic [7:0]  vi [3] = '{8'h80, 8'h3c, 8'h55};
  logic [7:0]  vp [3] = '{8'hff, 8'h10, 8'h7e};
  logic [7:0]  vh [3] = '{8'h12, 8'h34, 8'h56};

  mdo_exec #(.DATA_AW(12), .PROG_AW(16)) uut (
    .core_clk(core_clk), .rst(rst), .op_start(op_start),
    .op_sel(op_sel), .op_addr(op_addr), .op_bit(op_bit),
    .op_imm(op_imm), .op_busy(op_busy), .op_done(op_done),
    .op_skip(op_skip), .op_dummy(op_dummy), .acc_load(acc_load),
    .acc_load_val(acc_load_val), .flags_load(flags_load),
    .flags_load_val(flags_load_val), .ptr_lo_load(ptr_lo_load),
    .ptr_lo_load_val(ptr_lo_load_val), .ptr_hi_load(ptr_hi_load),
    .ptr_hi_load_val(ptr_hi_load_val), .acc(acc),
    .status_flags(status_flags), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high),
    .table_high_byte(table_high_byte), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .prog_addr(prog_addr),
    .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // memories answer one cycle after the strobe; idle data keeps moving
  always @(posedge core_clk) begin
    mem_rdata <= mem_rd_en ? dmem[mem_addr] : ~mem_rdata;
    prog_rdata <= prog_rd_en ? (prog_addr ^ 16'h5aa5) : ~prog_rdata;
    if (mem_wr_en) dmem[mem_addr] <= mem_wdata;
  end

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected outcome of one operation from the instruction semantics
  task calc(input logic [4:0] sel, input int k);
    logic [8:0] s;
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] adj;
    logic       cin;
    logic [15:0] pw;
    a = va[k];
    m = vm[k];
    ea = a;
    em = m;
    ef = vf[k];
    ep = vp[k] + ((sel == `MDO_OP_ITBL_PAGE || sel == 5'h08) ? 8'h01 : 8'h00);
    cin = (sel == `MDO_OP_ADC_ACC || sel == `MDO_OP_ADC_MEM) & vf[k][0];
    s = {1'b0, a} + {1'b0, m} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(cin);
    adj = {(a[7:4] > 4'h9 || vf[k][0]) ? 4'h6 : 4'h0,
           (a[3:0] > 4'h9 || vf[k][1]) ? 4'h6 : 4'h0};
    d = {1'b0, a} + {1'b0, adj};
    pw = {(sel == `MDO_OP_TBL_LAST || sel == 5'h08) ? 8'hff : vh[k], ep};
    pw = pw ^ 16'h5aa5;
    es = (sel == `MDO_OP_SKZ || sel == `MDO_OP_SKZ_MOV) ? (m == 8'h00) :
         (sel == `MDO_OP_SKZ_BIT) ? !m[vb[k]] : 1'b0;
    case (sel)
      5'h00, 5'h01: r = {m[3:0], m[7:4]};
      5'h05, 5'h06, 5'h07, 5'h08: r = pw[7:0];
      5'h09, 5'h0a: r = a ^ m;
      `MDO_OP_XOR_IMM: r = a ^ vi[k];
      5'h0c, 5'h0d, 5'h0e, 5'h0f: r = s[7:0];
      5'h10, 5'h11: r = a & m;
      `MDO_OP_CLR: r = 8'h00;
      `MDO_OP_CLR_BIT: r = m & ~(8'h01 << vb[k]);
      5'h14, 5'h15: r = ~m;
      `MDO_OP_DAA: r = d[7:0];
      5'h17, 5'h18: r = m - 8'h01;
      5'h19, 5'h1a: r = m + 8'h01;
      `MDO_OP_MOV_TO_MEM: r = a;
      default: r = m;
    endcase
    if (sel inside {5'h01, 5'h03, 5'h09, 5'h0b, 5'h0c, 5'h0e, 5'h10,
                    5'h15, 5'h18, 5'h1a, 5'h1b}) ea = r;
    if (sel inside {5'h00, [5'h05:5'h08], 5'h0a, 5'h0d, 5'h0f, 5'h11,
                    [5'h12:5'h14], 5'h16, 5'h17, 5'h19, 5'h1c}) em = r;
    if (sel inside {[5'h05:5'h08]}) et = pw[15:8];
    if (sel inside {[5'h09:5'h11], 5'h14, 5'h15, [5'h17:5'h1a]})
      ef[2] = (r == 8'h00);
    if (sel inside {[5'h0c:5'h0f]}) begin
      ef[0] = s[8];
      ef[1] = h[4];
      ef[3] = (a[7] == m[7]) && (s[7] != a[7]);
      ef[4] = ef[3] ^ s[7];
    end
    if (sel == `MDO_OP_DAA) ef[0] = vf[k][0] | d[8];
  endtask

  // load architectural state, then issue one operation and wait for it
  task run_case(input int k, input logic [4:0] sel);
    logic [11:0] adr;
    int          bn;
    logic        sk;
    logic        dm;
    adr = (k == 1) ? 12'h010 + 12'(sel) : 12'hfff - 12'(sel);
    bn = 0;
    sk = 1'b0;
    dm = 1'b0;
    @(posedge core_clk);
    {acc_load, flags_load, ptr_lo_load, ptr_hi_load} <= 4'hf;
    acc_load_val <= va[k];
    flags_load_val <= vf[k];
    ptr_lo_load_val <= vp[k];
    ptr_hi_load_val <= vh[k];
    @(posedge core_clk);
    {acc_load, flags_load, ptr_lo_load, ptr_hi_load} <= 4'h0;
    dmem[adr] = vm[k];
    calc(sel, k);
    @(posedge core_clk);
    op_start <= 1'b1;
    op_sel <= sel;
    op_addr <= adr;
    op_bit <= vb[k];
    op_imm <= vi[k];
    @(posedge core_clk);
    op_start <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      #1;
      if (op_busy === 1'b1) bn++;
      if (op_skip === 1'b1) sk = 1'b1;
      if (op_dummy === 1'b1) dm = 1'b1;
      if (op_done === 1'b1) break;
      @(posedge core_clk);
    end
    if (op_done !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: operation never finished", $time);
      summarize;
    end
    @(posedge core_clk);
    #1;
    chk(16'(acc), 16'(ea));
    chk(16'(status_flags), 16'(ef));
    chk(16'(dmem[adr]), 16'(em));
    chk(16'(table_high_byte), 16'(et));
    chk(16'(table_pointer_low), 16'(ep));
    chk(16'({sk, dm}), {14'h0000, es, es});
    chk(16'(bn), (sel inside {[5'h05:5'h08]}) ? 16'h0004 :
        es ? 16'h0003 : 16'h0002);
  endtask

  initial begin
    rst = 1'b1;
    {op_start, acc_load, flags_load, ptr_lo_load, ptr_hi_load} = 5'h00;
    op_sel = 5'h00;
    op_addr = 12'h000;
    op_bit = 3'h0;
    op_imm = 8'h00;
    acc_load_val = 8'h00;
    flags_load_val = 5'h00;
    ptr_lo_load_val = 8'h00;
    ptr_hi_load_val = 8'h00;
    mem_rdata = 8'h00;
    prog_rdata = 16'h0000;
    et = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(16'({acc, status_flags, op_busy}), 16'h0000);
    // every operation code against every operand set
    for (int k = 0; k < 3; k++) begin
      for (int o = 0; o <= 28; o++) begin
        run_case(k, 5'(o));
      end
    end
    summarize;
  end
endmodule // tb_mdo_exec

bind mdo_exec mdo_exec_monitor #(.DATA_AW(DATA_AW), .PROG_AW(PROG_AW))
  u_mon (.core_clk(core_clk), .rst(rst), .op_start(op_start),
  .op_sel(op_sel), .op_addr(op_addr), .op_busy(op_busy),
  .op_done(op_done), .op_skip(op_skip), .op_dummy(op_dummy),
  .status_flags(status_flags), .table_pointer_low(table_pointer_low),
  .table_pointer_high(table_pointer_high), .mem_addr(mem_addr),
  .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .prog_addr(prog_addr),
  .prog_rd_en(prog_rd_en));
`default_nettype wire
